// File: design/adcc_avg.sv
`timescale 1ns/100ps
// accumulates 1, 4 or 16 raw samples and delivers one scaled result
module adcc_avg (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // control
   input  wire logic        clear,
   input  wire logic [1:0]  enh,
   // raw samples
   input  wire logic        sample_valid,
   input  wire logic [9:0]  sample,
   // results
   output logic             last,
   output logic             result_valid_r,
   output logic [11:0]      result_r
);
   logic [3:0]  cnt_r;
   logic [13:0] sum_r;
   logic [13:0] sum_nxt;

   // last sample of the group decides when a result leaves
   always_comb begin
      unique case (enh)
         adcc_pkg::ENH_11: last = (cnt_r == 4'h3);
         adcc_pkg::ENH_12: last = (cnt_r == 4'hF);
         default:          last = 1'b1;
      endcase
   end
   assign sum_nxt = sum_r + {4'h0, sample};

   // accumulator and sample counter
   always_ff @(posedge clock) begin
      if (reset || clear) begin
         cnt_r <= 4'h0;
         sum_r <= 14'h0000;
      end else if (sample_valid) begin
         cnt_r <= last ? 4'h0 : cnt_r + 4'h1;
         sum_r <= last ? 14'h0000 : sum_nxt;
      end
   end

   // scaled result: sum of 4 halved gives 11 bits, sum of 16 quartered gives 12
   always_ff @(posedge clock) begin
      if (reset) begin
         result_valid_r <= 1'b0;
         result_r       <= 12'h000;
      end else begin
         result_valid_r <= sample_valid && last && !clear;
         if (sample_valid && last) begin
            unique case (enh)
               adcc_pkg::ENH_11: result_r <= {1'b0, sum_nxt[11:1]};
               adcc_pkg::ENH_12: result_r <= sum_nxt[13:2];
               default:          result_r <= {2'h0, sample};
            endcase
         end
      end
   end
endmodule // adcc_avg

// File: design/adcc_cmp.sv
`timescale 1ns/100ps
// window comparison of one value against two thresholds
module adcc_cmp (
   // operands
   input  wire logic [11:0] value,
   input  wire logic [11:0] low,
   input  wire logic [11:0] high,
   input  wire logic [1:0]  mode,
   // verdict
   output logic             match
);
   always_comb begin
      unique case (mode)
         adcc_pkg::CMP_LOW:  match = (value < low);
         adcc_pkg::CMP_HIGH: match = (value > high);
         adcc_pkg::CMP_IN:   match = (value >= low) && (value <= high);
         default:            match = (value < low) || (value > high);
      endcase
   end
endmodule // adcc_cmp

// File: design/adcc_ctrl.sv
// Function
// - results are full 10-bit, or 8-bit when low resolution is selected; with 11- or 12-bit mode also set, the code ignores low resolution
// - low resolution keeps conversion timing exactly as at full resolution
// - low-resolution results are byte sized for byte-wide DMA transfers
// - every result goes to the common register and its channel register
// - 11-bit mode averages four samples, one result per four conversions
// - 12-bit mode averages sixteen samples, one result per sixteen conversions
// - channel 7 is routed to the internal temperature sensor
// - channel 6 is routed to the internal backup supply
// - two control bits choose external reference pin or internal reference
// - eight-way input multiplexer, each channel individually enabled or disabled
// - start by software, external trigger input or selected timer output
// - compare flags below low, above high, inside or outside the window
// - sleep: power up on trigger, convert enabled channels, power down
// - enabling a channel hands its shared line to the converter
// - configuration writes work with conversion clock gated off
// - one start converts all enabled channels, then the sequencer idles; user sequence runs slots 0..5, each gated by the enable of its slot number
// - reading a channel result register clears its done flag
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module adcc_ctrl (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // conversion clock from the power manager is running
   input  wire logic        conv_clock_on,
   // triggers
   input  wire logic        external_trigger_input,
   input  wire logic [2:0]  timer_waveform_output_a,
   // analog cell and multiplexer
   output logic             cell_power,
   output logic             cell_start_r,
   output logic [2:0]       mux_sel_r,
   output logic             temp_path_r,
   output logic             backup_path_r,
   input  wire logic        cell_done,
   input  wire logic [9:0]  cell_data,
   // reference and sensor control
   output logic             internal_ref_on,
   output logic             internal_ref_force,
   output logic             temp_sensor_power,
   // shared pins handed to the converter
   output logic [3:0]       analog_inputs_sel,
   // peripheral_dma_channel request
   output logic             dma_req_r,
   output logic [15:0]      dma_data_r,
   output logic             dma_byte,
   // interrupt
   output logic             irq
);
   logic [31:0] mode_r, seq_r, emr_r, cwr_r, imask_r;
   logic [7:0]  chen_r, eoc_r;
   logic [1:0]  acr_r;
   logic        temp_r, drdy_r, govre_r, compe_r;
   logic [11:0] res_r [8];
   logic [11:0] last_r;
   logic [2:0]  last_ch_r;
   logic [31:0] status;
   logic        wr_en, rd_en;
   logic        start_req;
   logic [2:0]  ext_q_r;
   logic [2:0]  tio_q_r;
   logic        hw_edge;
   adcc_pkg::adcc_state_t state_r;
   logic [2:0]  idx_r;
   logic [2:0]  cur_ch;
   logic        cur_en, idx_end;
   logic        awake_r;
   logic [12:0] wake_cnt_r;
   logic        avg_last, avg_valid;
   logic [11:0] avg_res;
   logic [11:0] deliver;
   logic [11:0] cmp_val;
   logic        cmp_hit;
   logic        lowres, useq, sleep;
   logic [1:0]  enh;
   logic        rd_hit;
   logic [7:0]  res_off;

   // apb qualifiers: zero wait states, so pready stays high
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign lowres  = mode_r[adcc_pkg::MODE_LOWRES] && (enh == adcc_pkg::ENH_OFF);
   assign useq    = mode_r[adcc_pkg::MODE_USEQ];
   assign sleep   = mode_r[adcc_pkg::MODE_SLEEP];
   assign enh     = mode_r[adcc_pkg::MODE_ENH +: 2];

   // configuration registers, written on the bus clock without the conversion clock
   always_ff @(posedge clock) begin
      if (reset) begin
         mode_r  <= {24'h000000, adcc_pkg::MODE_RST};
         seq_r   <= 32'h00000000;
         emr_r   <= 32'h00000000;
         cwr_r   <= 32'h00000000;
         acr_r   <= 2'h0;
         temp_r  <= 1'b0;
         chen_r  <= 8'h00;
         imask_r <= 32'h00000000;
      end else if (wr_en) begin
         unique case (paddr)
            adcc_pkg::MODE_OFF:  mode_r <= pwdata;
            adcc_pkg::SEQ_OFF:   seq_r  <= pwdata;
            adcc_pkg::EMR_OFF:   emr_r  <= pwdata;
            adcc_pkg::CWR_OFF:   cwr_r  <= pwdata;
            adcc_pkg::ACR_OFF:   acr_r  <= pwdata[1:0];
            adcc_pkg::TEMP_OFF:  temp_r <= pwdata[adcc_pkg::TEMP_PWR];
            adcc_pkg::CHEN_OFF:  chen_r <= chen_r | pwdata[7:0];
            adcc_pkg::CHDIS_OFF: chen_r <= chen_r & ~pwdata[7:0];
            adcc_pkg::IEN_OFF:   imask_r <= imask_r | pwdata;
            adcc_pkg::IDIS_OFF:  imask_r <= imask_r & ~pwdata;
            default: ;
         endcase
      end
   end

   // reference selection and sensor power are plain register bits
   assign internal_ref_on    = acr_r[adcc_pkg::ACR_ON];
   assign internal_ref_force = acr_r[adcc_pkg::ACR_FORCE];
   assign temp_sensor_power  = temp_r;
   // an enabled channel owns its shared pin; no pin-function write needed
   assign analog_inputs_sel  = chen_r[3:0];

   // trigger sources: rising edges of pins, software start bit
   always_ff @(posedge clock) begin
      if (reset) begin
         ext_q_r <= 3'h0;
         tio_q_r <= 3'h0;
      end else begin
         ext_q_r <= {ext_q_r[1:0], external_trigger_input};
         tio_q_r <= timer_waveform_output_a;
      end
   end
   always_comb begin
      hw_edge = 1'b0;
      if (mode_r[adcc_pkg::MODE_TRGSEL +: 3] == adcc_pkg::TRG_EXT) begin
         hw_edge = ext_q_r[1] && !ext_q_r[2];
      end else if (mode_r[adcc_pkg::MODE_TRGSEL +: 3] < adcc_pkg::TRG_EXT) begin
         hw_edge = timer_waveform_output_a[mode_r[adcc_pkg::MODE_TRGSEL +: 2]]
                   && !tio_q_r[mode_r[adcc_pkg::MODE_TRGSEL +: 2]];
      end
   end
   assign start_req = (wr_en && paddr == adcc_pkg::CTRL_OFF && pwdata[adcc_pkg::CTRL_START])
                      || (mode_r[adcc_pkg::MODE_TRGEN] && hw_edge);

   // sequence slot: user order or plain ascending index
   always_comb begin
      if (useq) begin
         cur_ch  = seq_r[idx_r * adcc_pkg::SEQ_PITCH +: 3];
         cur_en  = chen_r[idx_r];
         idx_end = (idx_r == 3'(adcc_pkg::SEQ_SLOTS - 1));
      end else begin
         cur_ch  = idx_r;
         cur_en  = chen_r[idx_r];
         idx_end = (idx_r == 3'h7);
      end
   end

   // conversion sequencer; steps only while the conversion clock runs
   always_ff @(posedge clock) begin
      if (reset || (wr_en && paddr == adcc_pkg::CTRL_OFF && pwdata[adcc_pkg::CTRL_SWRST])) begin
         state_r      <= adcc_pkg::ST_IDLE;
         idx_r        <= 3'h0;
         awake_r      <= 1'b0;
         wake_cnt_r   <= 13'h0000;
         cell_start_r <= 1'b0;
         mux_sel_r    <= 3'h0;
      end else if (conv_clock_on) begin
         cell_start_r <= 1'b0;
         unique case (state_r)
            adcc_pkg::ST_IDLE: begin
               idx_r <= 3'h0;
               if (start_req && sleep && !awake_r) begin
                  awake_r    <= 1'b1;
                  wake_cnt_r <= 13'(adcc_pkg::STARTUP_CYC - 1);
                  state_r    <= adcc_pkg::ST_WAKE;
               end else if (start_req) begin
                  awake_r <= 1'b1;
                  state_r <= adcc_pkg::ST_PICK;
               end
            end
            adcc_pkg::ST_WAKE: begin
               // triggers while waking are ignored, the sequence is already owed
               if (wake_cnt_r == 13'h0000) begin
                  state_r <= adcc_pkg::ST_PICK;
               end else begin
                  wake_cnt_r <= wake_cnt_r - 13'h0001;
               end
            end
            adcc_pkg::ST_PICK: begin
               if (cur_en) begin
                  mux_sel_r <= cur_ch;
                  state_r   <= adcc_pkg::ST_CONV;
               end else if (idx_end) begin
                  awake_r <= 1'b0;
                  state_r <= adcc_pkg::ST_IDLE;
               end else begin
                  idx_r <= idx_r + 3'h1;
               end
            end
            adcc_pkg::ST_CONV: begin
               // same start pulse whatever the resolution
               cell_start_r <= 1'b1;
               state_r      <= adcc_pkg::ST_WAIT;
            end
            adcc_pkg::ST_WAIT: begin
               if (cell_done && !avg_last) begin
                  state_r <= adcc_pkg::ST_CONV;
               end else if (cell_done && idx_end) begin
                  awake_r <= 1'b0;
                  state_r <= adcc_pkg::ST_IDLE;
               end else if (cell_done) begin
                  idx_r   <= idx_r + 3'h1;
                  state_r <= adcc_pkg::ST_PICK;
               end
            end
            default: state_r <= adcc_pkg::ST_IDLE;
         endcase
      end
   end

   // cell is powered always, or only during a sequence in sleep operation
   assign cell_power = !sleep || awake_r;

   // internal lines follow the multiplexer select
   always_ff @(posedge clock) begin
      if (reset) begin
         temp_path_r   <= 1'b0;
         backup_path_r <= 1'b0;
      end else begin
         temp_path_r   <= (mux_sel_r == adcc_pkg::CH_TEMP);
         backup_path_r <= (mux_sel_r == adcc_pkg::CH_BACKUP);
      end
   end

   // averaging of consecutive samples for enhanced resolution
   adcc_avg u_avg (
      .clock        (clock),
      .reset        (reset),
      .clear        (state_r == adcc_pkg::ST_IDLE),
      .enh          (enh),
      .sample_valid (cell_done && state_r == adcc_pkg::ST_WAIT),
      .sample       (cell_data),
      .last         (avg_last),
      .result_valid_r (avg_valid),
      .result_r     (avg_res)
   );

   // low resolution keeps the top eight bits, upper bits read zero
   assign deliver = lowres ? {4'h0, avg_res[9:2]} : avg_res;
   // thresholds are always in full-resolution terms
   assign cmp_val = lowres ? {2'h0, avg_res[9:2], 2'h0} : avg_res;

   adcc_cmp u_cmp (
      .value (cmp_val),
      .low   (cwr_r[11:0]),
      .high  (cwr_r[adcc_pkg::CWR_HIGH +: 12]),
      .mode  (emr_r[adcc_pkg::EMR_CMPMODE +: 2]),
      .match (cmp_hit)
   );

   // result store: the channel being delivered is the current select
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < 8; i++) begin
            res_r[i] <= 12'h000;
         end
         last_r    <= 12'h000;
         last_ch_r <= 3'h0;
      end else if (avg_valid) begin
         res_r[mux_sel_r] <= deliver;
         last_r           <= deliver;
         last_ch_r        <= mux_sel_r;
      end
   end

   // sticky flags; a new event wins over a read that clears in the same cycle
   assign res_off = paddr - adcc_pkg::RES_OFF;  // addresses below the base wrap out of range
   assign rd_hit  = rd_en && (res_off < 8'h20);
   always_ff @(posedge clock) begin
      if (reset) begin
         eoc_r   <= 8'h00;
         drdy_r  <= 1'b0;
         govre_r <= 1'b0;
         compe_r <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (avg_valid && mux_sel_r == 3'(i)) begin
               eoc_r[i] <= 1'b1;
            end else if (rd_hit && res_off[4:2] == 3'(i)) begin
               eoc_r[i] <= 1'b0;
            end
         end
         if (avg_valid) begin
            drdy_r <= 1'b1;
         end else if (rd_en && paddr == adcc_pkg::LAST_OFF) begin
            drdy_r <= 1'b0;
         end
         if (avg_valid && drdy_r) begin
            govre_r <= 1'b1;
         end else if (rd_en && paddr == adcc_pkg::STAT_OFF) begin
            govre_r <= 1'b0;
         end
         if (avg_valid && cmp_hit && (emr_r[adcc_pkg::EMR_CMPALL]
             || emr_r[adcc_pkg::EMR_CMPSEL +: 3] == mux_sel_r)) begin
            compe_r <= 1'b1;
         end else if (rd_en && paddr == adcc_pkg::STAT_OFF) begin
            compe_r <= 1'b0;
         end
      end
   end

   // dma request per delivered result, byte wide in low resolution
   always_ff @(posedge clock) begin
      if (reset) begin
         dma_req_r  <= 1'b0;
         dma_data_r <= 16'h0000;
      end else begin
         dma_req_r <= avg_valid;
         if (avg_valid) begin
            dma_data_r <= {4'h0, deliver};
         end
      end
   end
   assign dma_byte = lowres;

   // status word and interrupt line
   always_comb begin
      status = {5'h00, compe_r, govre_r, drdy_r, 16'h0000, eoc_r};
   end
   assign irq = |(status & imask_r);

   // read data registered in the setup phase, valid through the access phase
   always_ff @(posedge clock) begin
      if (reset) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         unique case (paddr)
            adcc_pkg::CTRL_OFF, adcc_pkg::CHEN_OFF, adcc_pkg::CHDIS_OFF,
            adcc_pkg::IEN_OFF, adcc_pkg::IDIS_OFF: ;
            adcc_pkg::MODE_OFF:   prdata <= mode_r;
            adcc_pkg::SEQ_OFF:    prdata <= seq_r;
            adcc_pkg::EMR_OFF:    prdata <= emr_r;
            adcc_pkg::CWR_OFF:    prdata <= cwr_r;
            adcc_pkg::ACR_OFF:    prdata <= {30'h00000000, acr_r};
            adcc_pkg::TEMP_OFF:   prdata <= {31'h00000000, temp_r};
            adcc_pkg::CHSTAT_OFF: prdata <= {24'h000000, chen_r};
            adcc_pkg::IMASK_OFF:  prdata <= imask_r;
            adcc_pkg::STAT_OFF:   prdata <= status;
            adcc_pkg::LAST_OFF: begin
               prdata <= {16'h0000,
                          emr_r[adcc_pkg::EMR_TAG] ? {1'b0, last_ch_r} : 4'h0,
                          last_r};
            end
            default: begin
               if (res_off < 8'h20 && paddr[1:0] == 2'h0) begin
                  prdata <= {20'h00000, res_r[res_off[4:2]]};
               end else begin
                  pslverr <= 1'b1;
               end
            end
         endcase
      end
   end
endmodule // adcc_ctrl

// File: design/adcc_pkg.sv
package adcc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF    = 8'h00;  // control_reg
   localparam logic [7:0] MODE_OFF    = 8'h04;
   localparam logic [7:0] SEQ_OFF     = 8'h08;
   localparam logic [7:0] CHEN_OFF    = 8'h10;  // channel_enable_reg
   localparam logic [7:0] CHDIS_OFF   = 8'h14;
   localparam logic [7:0] CHSTAT_OFF  = 8'h18;
   localparam logic [7:0] LAST_OFF    = 8'h20;
   localparam logic [7:0] IEN_OFF     = 8'h24;
   localparam logic [7:0] IDIS_OFF    = 8'h28;
   localparam logic [7:0] IMASK_OFF   = 8'h2C;
   localparam logic [7:0] STAT_OFF    = 8'h30;
   localparam logic [7:0] TEMP_OFF    = 8'h34;  // temp_sensor_mode_reg
   localparam logic [7:0] EMR_OFF     = 8'h40;
   localparam logic [7:0] CWR_OFF     = 8'h44;
   localparam logic [7:0] RES_OFF     = 8'h50;  // channel_result_reg 0..7, one word each
   localparam logic [7:0] ACR_OFF     = 8'h94;  // analog_control_reg
   // control_reg fields
   localparam int unsigned CTRL_SWRST = 0;
   localparam int unsigned CTRL_START = 1;
   // mode fields
   localparam int unsigned MODE_TRGEN  = 0;
   localparam int unsigned MODE_TRGSEL = 1;  // 3 bits
   localparam int unsigned MODE_LOWRES = 4;
   localparam int unsigned MODE_SLEEP  = 5;
   localparam int unsigned MODE_ENH    = 6;  // 2 bits
   localparam int unsigned MODE_USEQ   = 8;
   // trigger select codes: timer outputs a0..a2, external pin
   localparam logic [2:0] TRG_EXT = 3'h3;
   // enhanced resolution codes
   localparam logic [1:0] ENH_OFF = 2'h0;
   localparam logic [1:0] ENH_11  = 2'h1;
   localparam logic [1:0] ENH_12  = 2'h2;
   // user sequence: six 3-bit slots on 4-bit pitch
   localparam int unsigned SEQ_SLOTS = 6;
   localparam int unsigned SEQ_PITCH = 4;
   // extended mode fields
   localparam int unsigned EMR_CMPMODE = 0;  // 2 bits
   localparam int unsigned EMR_CMPSEL  = 4;  // 3 bits
   localparam int unsigned EMR_CMPALL  = 9;
   localparam int unsigned EMR_TAG     = 24;
   localparam int unsigned CWR_HIGH    = 16;
   // comparison modes
   localparam logic [1:0] CMP_LOW  = 2'h0;
   localparam logic [1:0] CMP_HIGH = 2'h1;
   localparam logic [1:0] CMP_IN   = 2'h2;
   localparam logic [1:0] CMP_OUT  = 2'h3;
   // status / interrupt bit positions (0..7 are end of conversion)
   localparam int unsigned ST_DRDY  = 24;
   localparam int unsigned ST_GOVRE = 25;
   localparam int unsigned ST_COMPE = 26;
   // analog_control_reg and temp_sensor_mode_reg bits
   localparam int unsigned ACR_ON    = 0;
   localparam int unsigned ACR_FORCE = 1;
   localparam int unsigned TEMP_PWR  = 0;
   // internal channels and channels without wiring
   localparam logic [2:0] CH_BACKUP = 3'h6;
   localparam logic [2:0] CH_TEMP   = 3'h7;
   localparam logic [7:0] CH_UNWIRED = 8'h30;
   // analog cell start-up in sleep operation
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned STARTUP_US    = 20;
   localparam int unsigned STARTUP_CYC   = STARTUP_US * CLK_MHZ;
   localparam logic [7:0]  MODE_RST      = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAKE = 3'b001,
      ST_PICK = 3'b010,
      ST_CONV = 3'b011,
      ST_WAIT = 3'b100
   } adcc_state_t;
endpackage

// File: test/adcc_cell_model.sv
`timescale 1ns/100ps
// analog cell: answers each start after a short or a long conversion
module adcc_cell_model (
   // clock
   input  wire logic       clock,
   // from the controller
   input  wire logic       cell_start_r,
   input  wire logic [2:0] mux_sel_r,
   input  wire logic       slow,
   // to the controller
   output logic            cell_done,
   output logic [9:0]      cell_data
);
   int unsigned cnt = 0;
   initial {cell_done, cell_data} = 11'h000;
   // data toggles outside the done cycle so a stale sample never looks valid
   always @(posedge clock) begin
      cell_done <= 1'b0;
      cell_data <= ~cell_data;
      if (cell_start_r === 1'b1) cnt <= slow ? 9 : 3;
      else if (cnt != 0) cnt <= cnt - 1;
      if (cnt == 1) begin
         cell_done <= 1'b1;
         cell_data <= {mux_sel_r, 7'h55};
      end
   end
endmodule // adcc_cell_model

// File: test/adcc_ctrl_sva.sv
`timescale 1ns/100ps
// port checks of the controller
module adcc_ctrl_sva (
   // clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   // converter side
   input wire logic        cell_start_r,
   input wire logic [2:0]  mux_sel_r,
   input wire logic        temp_path_r,
   input wire logic        backup_path_r,
   input wire logic        internal_ref_on,
   input wire logic [3:0]  analog_inputs_sel,
   input wire logic        dma_req_r,
   input wire logic [15:0] dma_data_r,
   input wire logic        dma_byte
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // access phase writing one offset
   sequence wr_s(logic [7:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence
   // route flags lag the select by one cycle; skip the edge after reset
   temp_route_a: assert property (!$past(reset) |->
      temp_path_r == ($past(mux_sel_r) == adcc_pkg::CH_TEMP)) else $error("temp route wrong");
   backup_route_a: assert property (!$past(reset) |->
      backup_path_r == ($past(mux_sel_r) == adcc_pkg::CH_BACKUP)) else $error("backup route");
   chan_hand_a: assert property (wr_s(adcc_pkg::CHEN_OFF) |=>
      (analog_inputs_sel & $past(pwdata[3:0])) == $past(pwdata[3:0])) else $error("no handover");
   chan_drop_a: assert property (wr_s(adcc_pkg::CHDIS_OFF) |=>
      (analog_inputs_sel & $past(pwdata[3:0])) == 4'h0) else $error("line not released");
   ref_ctrl_a: assert property (wr_s(adcc_pkg::ACR_OFF) |=>
      internal_ref_on == $past(pwdata[0])) else $error("reference bit wrong");
   start_pulse_a: assert property (cell_start_r |=> !cell_start_r)
      else $error("start too long");
   dma_pulse_a: assert property (dma_req_r |=> !dma_req_r) else $error("dma pulse long");
   byte_res_a: assert property (dma_req_r && dma_byte |-> dma_data_r[15:8] == 8'h00)
      else $error("byte result too wide");
   full_res_a: assert property (dma_req_r && !dma_byte |-> dma_data_r[15:12] == 4'h0)
      else $error("result too wide");
endmodule // adcc_ctrl_sva

// File: test/test_adcc_ctrl.sv
`timescale 1ns/100ps
module test_adcc_ctrl;
   logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, conv_clock_on = 1'b0, external_trigger_input = 1'b0, slow = 1'b0;
   logic [2:0] timer_waveform_output_a = 3'h0, mux_sel_r, seen[$];
   logic cell_power, cell_start_r, temp_path_r, backup_path_r, cell_done, internal_ref_on;
   logic internal_ref_force, temp_sensor_power, dma_req_r, dma_byte, irq;
   logic [9:0] cell_data;
   logic [3:0] analog_inputs_sel;
   logic [15:0] dma_data_r;
   int errors = 0, n_tests = 0, n_res = 0, n_done = 0, cyc = 0, t_res = 0, t0 = 0, dur;
   int chs[4] = '{0, 2, 6, 7};
   adcc_ctrl DUT (.*);
   adcc_cell_model CELL (.clock, .cell_start_r, .mux_sel_r, .slow, .cell_done, .cell_data);
   initial forever #5 clock = ~clock;
   // counts raw conversions and results, keeps the channel order
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cell_start_r === 1'b1) seen.push_back(mux_sel_r);
      if (cell_done === 1'b1) n_done <= n_done + 1;
      if (dma_req_r === 1'b1) begin
         n_res <= n_res + 1;
         t_res <= cyc;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one apb transfer; the idle edge first keeps drives one per time step
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clock) penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      {psel, penable} <= 2'b00;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(q, e);
   endtask
   // trigger 0..2 timer output, 3 pin, 4 start bit; wait for n results
   task automatic fire(input int k, input int n);
      n_res <= 0;
      n_done <= 0;
      seen.delete();
      t0 = cyc;
      if (k > 3) xfer(adcc_pkg::CTRL_OFF, 1'b1, 32'h2);
      else begin
         @(posedge clock);
         if (k == 3) external_trigger_input <= 1'b1;
         else timer_waveform_output_a[k] <= 1'b1;
         repeat (2) @(posedge clock);
         {external_trigger_input, timer_waveform_output_a} <= 4'h0;
      end
      for (int i = 0; i < 5000 && n_res < n; i++) @(posedge clock);
      repeat (8) @(posedge clock);
      #1;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      rd(adcc_pkg::MODE_OFF, 32'h0);
      rd(8'hFC, 32'h0);
      chk(pslverr, 1'b1);
      // setup with the conversion clock stopped
      xfer(adcc_pkg::ACR_OFF, 1'b1, 32'h3);
      xfer(adcc_pkg::TEMP_OFF, 1'b1, 32'h1);
      xfer(adcc_pkg::CHEN_OFF, 1'b1, 32'hC5);
      xfer(adcc_pkg::IEN_OFF, 1'b1, 32'h0100_0000);
      chk({internal_ref_force, internal_ref_on, temp_sensor_power}, 3'h7);
      chk(analog_inputs_sel, 4'h5);
      rd(adcc_pkg::CHSTAT_OFF, 32'hC5);
      fire(4, 1);
      chk(n_res, 0);
      conv_clock_on <= 1'b1;
      $display("test setup done");
      fire(4, 4);
      dur = t_res - t0;
      chk(seen.size(), 4);
      foreach (chs[i]) chk(seen[i], chs[i]);
      chk(irq, 1'b1);
      rd(adcc_pkg::STAT_OFF, 32'h0300_00C5);
      foreach (chs[i]) rd(adcc_pkg::RES_OFF + 8'(4 * chs[i]), {chs[i][2:0], 7'h55});
      rd(adcc_pkg::STAT_OFF, 32'h0100_0000);
      rd(adcc_pkg::LAST_OFF, 32'h3D5);
      chk(irq, 1'b0);
      xfer(adcc_pkg::MODE_OFF, 1'b1, 32'h10);
      fire(4, 4);
      chk(t_res - t0, dur);
      rd(adcc_pkg::RES_OFF + 8'h08, 32'h55);
      chk(dma_byte, 1'b1);
      $display("test sequence done");
      for (int e = 1; e < 3; e++) begin
         slow <= e[1];
         xfer(adcc_pkg::MODE_OFF, 1'b1, 32'(e << 6));
         fire(4, 4);
         chk(n_done, (e == 1) ? 16 : 64);
      end
      slow <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         xfer(adcc_pkg::MODE_OFF, 1'b1, 32'(1 + 2 * k));
         fire(k, 4);
         chk(n_res, 4);
      end
      xfer(adcc_pkg::SEQ_OFF, 1'b1, 32'h306);
      xfer(adcc_pkg::MODE_OFF, 1'b1, 32'h100);
      fire(4, 2);
      chk({26'(seen.size()), seen[0], seen[1]}, {26'd2, 6'o63});
      xfer(adcc_pkg::MODE_OFF, 1'b1, 32'h0);
      xfer(adcc_pkg::CWR_OFF, 1'b1, 32'h0600_0100);
      for (int m = 0; m < 4; m++) begin
         xfer(adcc_pkg::EMR_OFF, 1'b1, 32'(32'h20 + m));
         fire(4, 4);
         xfer(adcc_pkg::STAT_OFF, 1'b0, 32'h0);
         chk(q[26], m == 2);
      end
      $display("test modes done");
      xfer(adcc_pkg::MODE_OFF, 1'b1, 32'h20);
      xfer(adcc_pkg::CHDIS_OFF, 1'b1, 32'h1);
      chk(cell_power, 1'b0);
      fire(4, 3);
      chk({n_res[7:0], cell_power, t_res - t0 > 2000}, {8'd3, 2'b01});
      $display("test sleep done");
      report_and_stop;
   end
endmodule // test_adcc_ctrl
bind adcc_ctrl adcc_ctrl_sva CHK (.*);
